// [fbe_pkg.sv]
// package: constants for the flash block erase sequencer
package fbe_pkg;
   // ***************************************************
   // memory control register layout
   // ***************************************************
   localparam int FBE_CTRL_W = 8;
   localparam int FBE_BIT_RD = 0;
   localparam int FBE_BIT_WR = 1;
   localparam int FBE_BIT_WRITE_ENABLE_BIT = 2;
   localparam int FBE_BIT_WRITE_ERROR_FLAG = 3;
   localparam int FBE_BIT_FREE = 4;
   localparam int FBE_BIT_CONFIG_SPACE_SELECT = 6;
   localparam int FBE_BIT_PGM = 7;
   localparam logic [7:0] FBE_CTRL_RST = 8'h00;
   // ***************************************************
   // unlock keys and pointer fields
   // ***************************************************
   localparam logic [7:0] FBE_KEY1 = 8'h55;
   localparam logic [7:0] FBE_KEY2 = 8'haa;
   localparam int FBE_PTR_W = 22;
   localparam int FBE_BLK_LSB = 6;
   localparam int FBE_BLK_W = FBE_PTR_W - FBE_BLK_LSB;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int FBE_CLK_MHZ = 250;
   localparam int FBE_TIW_US = 1000;
   localparam int FBE_TIW_CYC = FBE_TIW_US * FBE_CLK_MHZ;
   // ***************************************************
   // host register offsets (command/pointer/status/interrupt/mask) and command codes
   // ***************************************************
   localparam int FBE_AW = 4;
   localparam logic [3:0] FBE_REG_CMD = 4'h0;
   localparam logic [3:0] FBE_REG_PTR = 4'h1;
   localparam logic [3:0] FBE_REG_STAT = 4'h2;
   localparam logic [3:0] FBE_REG_INT = 4'h3;
   localparam logic [3:0] FBE_REG_MASK = 4'h4;
   localparam logic [2:0] FBE_OP_CTRL = 3'h1;
   localparam logic [2:0] FBE_OP_KEY = 3'h2;
   localparam logic [2:0] FBE_OP_PTR = 3'h3;
   localparam logic [2:0] FBE_OP_RDCTRL = 3'h4;
   localparam logic [2:0] FBE_OP_RDKEY = 3'h5;
endpackage

// [fbe_if.sv]
// interface: core-side bus between host end and erase sequencer
`timescale 1ns/1ps
interface fbe_if;
   logic ctrl_wr;
   logic ctrl_rd;
   logic [7:0] ctrl_wdata;
   logic [7:0] ctrl_rdata;
   logic key_wr;
   logic key_rd;
   logic [7:0] key_wdata;
   logic [7:0] key_rdata;
   logic ptr_wr;
   logic [21:0] ptr_wdata;
   logic cpu_stall;
   logic nvm_done_flag;
   logic nvm_done_clr;
   logic [15:0] erase_block;
   logic erase_pulse;
   modport device (
      input ctrl_wr, ctrl_rd, ctrl_wdata, key_wr, key_rd, key_wdata, ptr_wr,
      ptr_wdata, nvm_done_clr,
      output ctrl_rdata, key_rdata, cpu_stall, nvm_done_flag, erase_block,
      erase_pulse
   );
   modport host (
      output ctrl_wr, ctrl_rd, ctrl_wdata, key_wr, key_rd, key_wdata, ptr_wr,
      ptr_wdata, nvm_done_clr,
      input ctrl_rdata, key_rdata, cpu_stall, nvm_done_flag, erase_block,
      erase_pulse
   );
endinterface

// [fbe_device.sv]
// module: flash block erase sequencer, device end
`timescale 1ns/1ps
// Summary of operation
// - erase whole blocks of 32 or 64 words
// - no single-word erase, block is minimum
// - block chosen by pointer bits 21:6, bits 21:7 on large parts
// - pointer bits 5:0 ignored on erase
// - firmware sets program, enable, erase bits first
// - firmware clears configuration select bit
// - 0x55 then 0xAA then start bit
// - firmware masks interrupts around unlock
// - start after unlock with erase begins cycle
// - core stalled during whole erase cycle
// - timer expiry ends cycle, core resumes
// - start bit set-only, hardware clears it
// - error flag set on start, cleared normally
// - done flag set on completion, firmware clears
// - enable clear at reset, key reads zero
module fbe_device
   import fbe_pkg::*;
#(
   parameter int TIW_CYCLES = fbe_pkg::FBE_TIW_CYC,
   parameter bit LARGE_MEM = 1'b0
) (
   input wire logic sys_clk,
   input wire logic rst,
   fbe_if.device bus
);
   import fbe_pkg::*;

   typedef enum logic [1:0] {FBE_K_IDLE, FBE_K_ONE, FBE_K_TWO} fbe_key_t;

   logic [7:0] ctrl, next_ctrl;
   logic [21:0] ptr, next_ptr;
   fbe_key_t key, next_key;
   logic [31:0] tmr, next_tmr;
   logic busy, next_busy;
   logic done, next_done;
   logic pulse, next_pulse;
   logic [7:0] rdata, next_rdata;
   logic [15:0] blk, next_blk;
   logic start_ok;
   logic done_set;

   // ***************************************************
   // unlock and start
   // ***************************************************
   assign start_ok = bus.ctrl_wr && bus.ctrl_wdata[FBE_BIT_WR] && !ctrl[FBE_BIT_WR]
      && key == FBE_K_TWO && ctrl[FBE_BIT_WRITE_ENABLE_BIT] && !busy;

   // ***************************************************
   // unlock key order
   // ***************************************************
   // 0x55 always restarts the order and any other write but the expected next key breaks it, so an
   // interrupt handler touching the port between keys voids the unlock
   always_comb begin
      next_key = key;
      if (start_ok) begin
         // a used unlock is spent; the next start needs fresh keys
         next_key = FBE_K_IDLE;
      end else if (bus.key_wr) begin
         if (bus.key_wdata == FBE_KEY1) begin
            next_key = FBE_K_ONE;
         end else if (bus.key_wdata == FBE_KEY2 && key == FBE_K_ONE) begin
            next_key = FBE_K_TWO;
         end else begin
            next_key = FBE_K_IDLE;
         end
      end else if (bus.ctrl_wr || bus.ptr_wr) begin
         next_key = FBE_K_IDLE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         key <= FBE_K_IDLE;
      end else begin
         key <= next_key;
      end
   end

   // ***************************************************
   // table pointer
   // ***************************************************
   // pointer frozen while busy so the erased block cannot move mid-cycle
   always_comb begin
      next_ptr = ptr;
      if (bus.ptr_wr && !busy) begin
         next_ptr = bus.ptr_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ptr <= '0;
      end else begin
         ptr <= next_ptr;
      end
   end

   // ***************************************************
   // completion flag
   // ***************************************************
   // completion and clear in one cycle: completion wins, so firmware that
   // clears late never loses a finished operation
   assign done_set = (busy && tmr == 32'd0) || (!busy && ctrl[FBE_BIT_WR] && !start_ok);

   always_comb begin
      next_done = done;
      if (done_set) begin
         next_done = 1'b1;
      end else if (bus.nvm_done_clr) begin
         next_done = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         done <= 1'b0;
      end else begin
         done <= next_done;
      end
   end

   // ***************************************************
   // control read port
   // ***************************************************
   // read data live for one cycle only, zero otherwise
   always_comb begin
      next_rdata = 8'h00;
      if (bus.ctrl_rd) begin
         next_rdata = ctrl;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      next_tmr = tmr;
      next_busy = busy;
      next_pulse = 1'b0;
      next_blk = blk;
      if (bus.ctrl_wr && !busy) begin
         next_ctrl[FBE_BIT_PGM] = bus.ctrl_wdata[FBE_BIT_PGM];
         next_ctrl[FBE_BIT_CONFIG_SPACE_SELECT] = bus.ctrl_wdata[FBE_BIT_CONFIG_SPACE_SELECT];
         next_ctrl[FBE_BIT_FREE] = bus.ctrl_wdata[FBE_BIT_FREE];
         next_ctrl[FBE_BIT_WRITE_ENABLE_BIT] = bus.ctrl_wdata[FBE_BIT_WRITE_ENABLE_BIT];
         // error flag is software-clearable only
         next_ctrl[FBE_BIT_WRITE_ERROR_FLAG] = ctrl[FBE_BIT_WRITE_ERROR_FLAG] & bus.ctrl_wdata[FBE_BIT_WRITE_ERROR_FLAG];
      end
      if (start_ok) begin
         next_ctrl[FBE_BIT_WR] = 1'b1;
         next_ctrl[FBE_BIT_WRITE_ERROR_FLAG] = 1'b1;
         // only a program-space block erase runs the long cycle here
         if (bus.ctrl_wdata[FBE_BIT_PGM] && !bus.ctrl_wdata[FBE_BIT_CONFIG_SPACE_SELECT]
            && bus.ctrl_wdata[FBE_BIT_FREE]) begin
            next_busy = 1'b1;
            next_tmr = 32'(TIW_CYCLES - 1);
            next_pulse = 1'b1;
            // low bits dropped, on large parts bit 6 too (128-byte block)
            next_blk = ptr[21:6];
            if (LARGE_MEM) begin
               next_blk[0] = 1'b0;
            end
         end
      end
      if (busy) begin
         if (tmr == 32'd0) begin
            next_busy = 1'b0;
            next_ctrl[FBE_BIT_WR] = 1'b0;
            next_ctrl[FBE_BIT_WRITE_ERROR_FLAG] = 1'b0;
         end else begin
            next_tmr = tmr - 32'd1;
         end
      end else if (ctrl[FBE_BIT_WR] && !start_ok) begin
         // non-erase start: complete at once, no long cycle
         next_ctrl[FBE_BIT_WR] = 1'b0;
         next_ctrl[FBE_BIT_WRITE_ERROR_FLAG] = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl <= FBE_CTRL_RST;
         tmr <= '0;
         busy <= 1'b0;
         pulse <= 1'b0;
         blk <= '0;
      end else begin
         ctrl <= next_ctrl;
         tmr <= next_tmr;
         busy <= next_busy;
         pulse <= next_pulse;
         blk <= next_blk;
      end
   end

   assign bus.ctrl_rdata = rdata;
   assign bus.key_rdata = 8'h00;
   assign bus.cpu_stall = busy;
   assign bus.nvm_done_flag = done;
   assign bus.erase_block = blk;
   assign bus.erase_pulse = pulse;
endmodule

// [fbe_host.sv]
// module: firmware-side end issuing the erase sequence from a register port
`timescale 1ns/1ps
module fbe_host
   import fbe_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   output logic global_interrupt_enable,
   fbe_if.host bus
);
   import fbe_pkg::*;

   typedef enum logic [2:0] {FBE_H_IDLE, FBE_H_K1, FBE_H_K2, FBE_H_GO, FBE_H_WAIT1,
      FBE_H_WAIT, FBE_H_CHK} fbe_hst_t;

   fbe_hst_t st, next_st;
   logic [31:0] rd_q, next_rd_q;
   logic [1:0] ist, next_ist;
   logic [1:0] mask, next_mask;
   logic irq_q, next_irq_q;
   logic gie_q, next_gie_q;
   logic [7:0] cw, next_cw;
   logic c_wr, c_rd, k_wr, p_wr, d_clr;
   logic [7:0] c_wd, k_wd;
   logic [21:0] p_wd;
   logic [1:0] ev;

   // ***************************************************
   // command decode and sequence
   // ***************************************************
   // ev[0]: operation done, ev[1]: start refused or error flag left set
   // control read data lag one cycle, so judge only reads taken after the fact
   assign ev[0] = st == FBE_H_CHK;
   assign ev[1] = (st == FBE_H_CHK && bus.ctrl_rdata[FBE_BIT_WRITE_ERROR_FLAG])
      || (st == FBE_H_WAIT && !bus.nvm_done_flag && !bus.cpu_stall
      && !bus.ctrl_rdata[FBE_BIT_WR]);

   always_comb begin
      next_st = st;
      next_rd_q = 32'h0;
      next_ist = ist | ev;
      next_mask = mask;
      next_gie_q = gie_q;
      next_cw = cw;
      c_wr = 1'b0;
      c_rd = 1'b0;
      k_wr = 1'b0;
      p_wr = 1'b0;
      d_clr = 1'b0;
      c_wd = cw;
      k_wd = 8'h00;
      p_wd = wdata[21:0];
      if (wr && addr == FBE_REG_INT) begin
         next_ist = (ist & ~wdata[1:0]) | ev;
      end
      if (wr && addr == FBE_REG_MASK) begin
         next_mask = wdata[1:0];
      end
      if (rd) begin
         case (addr)
            FBE_REG_STAT: next_rd_q = {29'h0, bus.cpu_stall, bus.nvm_done_flag,
               st != FBE_H_IDLE};
            FBE_REG_INT: next_rd_q = {30'h0, ist};
            FBE_REG_MASK: next_rd_q = {30'h0, mask};
            default: next_rd_q = 32'h0;
         endcase
      end
      case (st)
         FBE_H_IDLE: begin
            if (wr && addr == FBE_REG_PTR) begin
               p_wr = 1'b1;
            end else if (wr && addr == FBE_REG_CMD && wdata[2:0] == FBE_OP_CTRL) begin
               next_cw = wdata[15:8];
               c_wd = wdata[15:8];
               c_wd[FBE_BIT_WR] = 1'b0;
               next_cw[FBE_BIT_WR] = 1'b0;
               c_wr = 1'b1;
            end else if (wr && addr == FBE_REG_CMD && wdata[2:0] == FBE_OP_KEY) begin
               next_gie_q = 1'b0;
               next_st = FBE_H_K1;
            end else if (wr && addr == FBE_REG_CMD && wdata[2:0] == FBE_OP_RDCTRL) begin
               c_rd = 1'b1;
            end
         end
         FBE_H_K1: begin
            k_wr = 1'b1;
            k_wd = FBE_KEY1;
            next_st = FBE_H_K2;
         end
         FBE_H_K2: begin
            k_wr = 1'b1;
            k_wd = FBE_KEY2;
            next_st = FBE_H_GO;
         end
         FBE_H_GO: begin
            c_wr = 1'b1;
            c_wd = cw | 8'h02;
            next_gie_q = 1'b1;
            d_clr = 1'b1;
            next_st = FBE_H_WAIT1;
         end
         FBE_H_WAIT1: begin
            c_rd = 1'b1;
            next_st = FBE_H_WAIT;
         end
         FBE_H_WAIT: begin
            c_rd = 1'b1;
            if (bus.nvm_done_flag && !bus.cpu_stall) begin
               next_st = FBE_H_CHK;
            end else if (ev[1]) begin
               // start bit never took: the device refused the request
               next_st = FBE_H_IDLE;
            end
         end
         FBE_H_CHK: begin
            d_clr = 1'b1;
            next_st = FBE_H_IDLE;
         end
         default: next_st = FBE_H_IDLE;
      endcase
      next_irq_q = |(next_ist & next_mask);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= FBE_H_IDLE;
         rd_q <= 32'h0;
         ist <= 2'b00;
         mask <= 2'b00;
         irq_q <= 1'b0;
         gie_q <= 1'b1;
         cw <= FBE_CTRL_RST;
      end else begin
         st <= next_st;
         rd_q <= next_rd_q;
         ist <= next_ist;
         mask <= next_mask;
         irq_q <= next_irq_q;
         gie_q <= next_gie_q;
         cw <= next_cw;
      end
   end

   assign rdata = rd_q;
   assign irq = irq_q;
   assign global_interrupt_enable = gie_q;
   assign bus.ctrl_wr = c_wr;
   assign bus.ctrl_rd = c_rd;
   assign bus.ctrl_wdata = c_wd;
   assign bus.key_wr = k_wr;
   assign bus.key_rd = 1'b0;
   assign bus.key_wdata = k_wd;
   assign bus.ptr_wr = p_wr;
   assign bus.ptr_wdata = p_wd;
   assign bus.nvm_done_clr = d_clr;
endmodule

// [fbe_monitor.sv]
// checker: ordering and timing properties of the erase sequencer bus
`timescale 1ns/1ps
module fbe_monitor #(
   parameter int TIW_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic key_wr,
   input wire logic [7:0] key_wdata,
   input wire logic [7:0] key_rdata,
   input wire logic ptr_wr,
   input wire logic [21:0] ptr_wdata,
   input wire logic cpu_stall,
   input wire logic nvm_done_flag,
   input wire logic nvm_done_clr,
   input wire logic [15:0] erase_block,
   input wire logic erase_pulse
);
   // ***************************************************
   // helper state
   // ***************************************************
   int stall_cnt;
   logic [15:0] blk;
   logic ok_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge sys_clk) begin
      if (rst || !cpu_stall)
         stall_cnt <= 0;
      else
         stall_cnt <= stall_cnt + 1;
      // pointer writes during a stall are dropped by the device
      if (ptr_wr && !cpu_stall)
         blk <= ptr_wdata[21:6];
      if (rst)
         ok_q <= 1'b0;
      else if (ctrl_wr && !ctrl_wdata[1])
         ok_q <= ctrl_wdata[7] && ctrl_wdata[4] && ctrl_wdata[2] && !ctrl_wdata[6];
   end
   // ***************************************************
   // properties
   // ***************************************************
   sequence s_keys;
      key_wr && key_wdata == 8'h55 ##1 key_wr && key_wdata == 8'haa;
   endsequence
   sequence s_start;
      s_keys ##1 ctrl_wr && ctrl_wdata[1];
   endsequence
   a_start_grants: assert property (s_start |=> erase_pulse == ok_q)
      else $error("start after unlock not handled as set up");
   a_unlock_needed: assert property (erase_pulse |-> $past(ctrl_wr) && $past(key_wr, 2)
      && $past(key_wdata, 2) == 8'haa && $past(key_wr, 3) && $past(key_wdata, 3) == 8'h55)
      else $error("erase began without the unlock order");
   a_stall_follows: assert property (erase_pulse |-> cpu_stall)
      else $error("core not stalled at erase start");
   a_stall_length: assert property ($fell(cpu_stall) |-> stall_cnt == TIW_CYCLES)
      else $error("stall length differs from timer");
   a_done_at_end: assert property ($fell(cpu_stall) |-> nvm_done_flag)
      else $error("done flag missing at erase end");
   a_done_sticky: assert property (nvm_done_flag && !nvm_done_clr |=> nvm_done_flag)
      else $error("done flag dropped without clear");
   a_key_reads_zero: assert property (key_rdata == 8'h00)
      else $error("key port read not zero");
   a_block_select: assert property (erase_pulse |-> erase_block == blk)
      else $error("erase block not from pointer upper bits");
   a_one_pulse: assert property (erase_pulse |=> !erase_pulse)
      else $error("erase start longer than one cycle");
endmodule

// [flash_block_erase_sequencer_tb_top.sv]
// testbench: host register port driving good and refused block erases
`timescale 1ns/1ps
module flash_block_erase_sequencer_tb_top;
   import fbe_pkg::*;
   // ***************************************************
   // environment
   // ***************************************************
   localparam int ERASE_WRITE_TIME = 20;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq;
   logic global_interrupt_enable;
   logic [31:0] v;
   logic [15:0] blk_seen;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n_pulse;
   int n_stall;
   fbe_if bus ();
   fbe_device #(.TIW_CYCLES(ERASE_WRITE_TIME), .LARGE_MEM(1'b0)) fbe_device_i (.sys_clk(sys_clk), .rst(rst),
      .bus(bus));
   fbe_host fbe_host_i (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .irq(irq), .global_interrupt_enable(global_interrupt_enable), .bus(bus));
   fbe_monitor #(.TIW_CYCLES(ERASE_WRITE_TIME)) fbe_monitor_i (.sys_clk(sys_clk), .rst(rst),
      .ctrl_wr(bus.ctrl_wr), .ctrl_wdata(bus.ctrl_wdata), .key_wr(bus.key_wr),
      .key_wdata(bus.key_wdata), .key_rdata(bus.key_rdata), .ptr_wr(bus.ptr_wr),
      .ptr_wdata(bus.ptr_wdata), .cpu_stall(bus.cpu_stall), .nvm_done_flag(bus.nvm_done_flag),
      .nvm_done_clr(bus.nvm_done_clr), .erase_block(bus.erase_block),
      .erase_pulse(bus.erase_pulse));
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic summarize();
      if (n_errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // pointer, control byte, then keys and start; counts what shows on the core bus
   task automatic run_seq(input logic [21:0] ptr, input logic [7:0] ctrl);
      wr_reg(FBE_REG_PTR, {10'h0, ptr});
      wr_reg(FBE_REG_CMD, {16'h0, ctrl, 5'h0, FBE_OP_CTRL});
      wr_reg(FBE_REG_CMD, {29'h0, FBE_OP_KEY});
      n_pulse = 0;
      n_stall = 0;
      for (int i = 0; i < 3 * ERASE_WRITE_TIME && bus.nvm_done_flag !== 1'b1; i++) begin
         @(negedge sys_clk);
         if (bus.erase_pulse === 1'b1) begin
            n_pulse++;
            blk_seen = bus.erase_block;
         end
         if (bus.cpu_stall === 1'b1)
            n_stall++;
      end
      repeat (4) @(posedge sys_clk);
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      rd_reg(FBE_REG_STAT, v);
      check("stat", v, 32'h0);
      rd_reg(FBE_REG_INT, v);
      check("int", v, 32'h0);
      check("irq", {31'h0, irq}, 32'h0);
      check("gie", {31'h0, global_interrupt_enable}, 32'h1);
   endtask
   // two pointers in one block; second run has the done interrupt masked
   task automatic t_erase();
      logic [21:0] p [2] = '{22'h2abcff, 22'h2abcc0};
      for (int i = 0; i < 2; i++) begin
         wr_reg(FBE_REG_MASK, {31'h0, i == 0});
         run_seq(p[i], 8'h94);
         check("pulses", 32'(n_pulse), 32'h1);
         check("block", {16'h0, blk_seen}, 32'h0000aaf3);
         check("stall", 32'(n_stall), 32'(ERASE_WRITE_TIME));
         check("irq", {31'h0, irq}, {31'h0, i == 0});
         rd_reg(FBE_REG_INT, v);
         check("int_done", v, 32'h1);
         wr_reg(FBE_REG_INT, 32'h1);
         rd_reg(FBE_REG_INT, v);
         check("int_clr", v, 32'h0);
         check("gie", {31'h0, global_interrupt_enable}, 32'h1);
      end
   endtask
   // enable clear, config space selected, erase not selected
   task automatic t_refused();
      logic [7:0] c [3] = '{8'h90, 8'hd4, 8'h84};
      wr_reg(FBE_REG_MASK, 32'h3);
      for (int i = 0; i < 3; i++) begin
         run_seq(22'h000040, c[i]);
         check("ref_pulse", 32'(n_pulse), 32'h0);
         check("ref_stall", 32'(n_stall), 32'h0);
      end
      rd_reg(FBE_REG_INT, v);
      check("ref_int", v, 32'h3);
      check("ref_irq", {31'h0, irq}, 32'h1);
      wr_reg(FBE_REG_INT, 32'h3);
      repeat (2) @(posedge sys_clk);
      check("irq_off", {31'h0, irq}, 32'h0);
   endtask
   // ***************************************************
   // run control
   // ***************************************************
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_erase();
      t_refused();
      summarize();
   end
endmodule
